// *** src/cfo_core.sv ***
// Four-phase executor for the clear, kick, invert and equal-skip instructions
//
// Summary of operation
// - zero_file_op writes 00h, sets zero flag
// - Bank bit 0 selects access bank
// - Bank bit 1 combines bank select register
// - Extended set, bank bit 0 offsets <=5Fh use indexing
// - watchdog_kick_op clears counter, sets both lows
// - invert_file_op complements, updates negative, zero
// - Destination 0 accumulator, 1 register
// - equal_skip_op compares by subtraction, no flags
// - Equality discards next word as idle_slot
// - Skipped two-word instruction costs two cycles
`timescale 1ns/1ps

module cfo_core
   import cfo_pkg::*;
(
   // Clock, reset and enable
   input wire logic ref_clk_i,
   input wire logic resetn_i,
   input wire logic clk_en_i,
   // Instruction fetch stream
   input wire logic [15:0] instr_i,
   input wire logic instr_valid_i,
   input wire logic instr_two_word_i,
   output logic fetch_ready_o,
   // Addressing configuration
   input wire logic [3:0] bank_select_reg_i,
   input wire logic ext_set_en_i,
   input wire logic [CFO_ADDR_W-1:0] index_base_i,
   // Data memory port
   output logic [CFO_ADDR_W-1:0] mem_addr_o,
   output logic mem_rd_o,
   input wire logic [7:0] mem_rdata_i,
   output logic mem_we_o,
   output logic [7:0] mem_wdata_o,
   // Accumulator preload and view
   input wire logic accum_load_i,
   input wire logic [7:0] accum_load_data_i,
   output logic [7:0] accum_o,
   // Status flags
   output logic all_clear_flag_o,
   output logic result_msb_flag_o,
   // Watchdog side
   input wire logic watchdog_expired_i,
   input wire logic sleep_entry_i,
   output logic watchdog_clear_o,
   output logic expiry_occurred_low_o,
   output logic sleep_entered_low_o,
   // Execution view
   output logic [3:0] phase_o,
   output logic skip_active_o
);

   // ***********************************************************************
   // State
   // ***********************************************************************
   cfo_phase_t phase_r, phase_nxt;
   cfo_op_t op_r, op_nxt;
   logic dest_r, dest_nxt;
   logic [1:0] skip_r, skip_nxt;
   logic [CFO_ADDR_W-1:0] addr_r, addr_nxt;
   logic we_r, we_nxt;
   logic [7:0] wdata_r, wdata_nxt;
   logic [7:0] operand_r, operand_nxt;
   logic [7:0] result_r, result_nxt;
   logic [7:0] accum_r, accum_nxt;
   logic zero_r, zero_nxt;
   logic neg_r, neg_nxt;
   logic kick_r, kick_nxt;
   logic expiry_low_r, expiry_low_nxt;
   logic sleep_low_r, sleep_low_nxt;

   // ***********************************************************************
   // Combinational helpers
   // ***********************************************************************
   logic [7:0] f_addr;
   logic bank_bit;
   logic [CFO_ADDR_W-1:0] eff_addr;
   logic [7:0] diff;
   logic [7:0] inv_val;

   // Operand fields of the word on offer
   assign f_addr = instr_i[7:0];
   assign bank_bit = instr_i[CFO_BANK_BIT];
   assign diff = operand_r - accum_r;
   assign inv_val = ~operand_r;

   // Effective data address
   always_comb
   begin
      if (bank_bit)
      begin
         eff_addr = {bank_select_reg_i, f_addr};
      end
      else if (ext_set_en_i && (f_addr <= CFO_INDEX_LIMIT))
      begin
         // Base plus literal offset, wraps inside data space
         eff_addr = index_base_i + {4'h0, f_addr};
      end
      else if (f_addr < CFO_ACCESS_SPLIT)
      begin
         eff_addr = {CFO_ACCESS_LOW_BANK, f_addr};
      end
      else
      begin
         eff_addr = {CFO_ACCESS_HIGH_BANK, f_addr};
      end
   end

   // ***********************************************************************
   // Next-state logic
   // ***********************************************************************
   // One phase per enabled clock; decode waits for a fetched word
   always_comb
   begin
      phase_nxt = phase_r;
      op_nxt = op_r;
      dest_nxt = dest_r;
      skip_nxt = skip_r;
      addr_nxt = addr_r;
      we_nxt = 1'b0;
      wdata_nxt = wdata_r;
      operand_nxt = operand_r;
      result_nxt = result_r;
      accum_nxt = accum_r;
      zero_nxt = zero_r;
      neg_nxt = neg_r;
      kick_nxt = 1'b0;
      expiry_low_nxt = expiry_low_r;
      sleep_low_nxt = sleep_low_r;
      unique case (phase_r)
         PH_DECODE:
         begin
            if (instr_valid_i)
            begin
               phase_nxt = PH_READ;
               dest_nxt = instr_i[CFO_DEST_BIT];
               addr_nxt = eff_addr;
               if (skip_r == CFO_SKIP_FIRST)
               begin
                  // Discarded word runs as an idle slot
                  op_nxt = OP_IDLE;
                  skip_nxt = instr_two_word_i ? CFO_SKIP_TAIL : CFO_SKIP_NONE;
               end
               else if (skip_r == CFO_SKIP_TAIL)
               begin
                  op_nxt = OP_IDLE;
                  skip_nxt = CFO_SKIP_NONE;
               end
               else if (instr_i == CFO_KICK_WORD)
               begin
                  op_nxt = OP_KICK;
               end
               else if (instr_i[15:9] == CFO_ZERO_TOP)
               begin
                  op_nxt = OP_ZERO;
               end
               else if (instr_i[15:10] == CFO_INV_TOP)
               begin
                  op_nxt = OP_INV;
               end
               else if (instr_i[15:9] == CFO_EQ_TOP)
               begin
                  op_nxt = OP_EQ;
               end
               else
               begin
                  // Words outside this set pass as idle slots
                  op_nxt = OP_IDLE;
               end
            end
         end
         PH_READ:
         begin
            phase_nxt = PH_PROC;
            // Only register operands read memory; kick and idle do not
            if ((op_r == OP_ZERO) || (op_r == OP_INV) || (op_r == OP_EQ))
            begin
               operand_nxt = mem_rdata_i;
            end
         end
         PH_PROC:
         begin
            phase_nxt = PH_WRITE;
            unique case (op_r)
               OP_ZERO:
               begin
                  result_nxt = CFO_CLEAR_VALUE;
                  zero_nxt = 1'b1;
                  we_nxt = 1'b1;
                  wdata_nxt = CFO_CLEAR_VALUE;
               end
               OP_INV:
               begin
                  result_nxt = inv_val;
                  neg_nxt = inv_val[7];
                  zero_nxt = (inv_val == 8'h00);
                  we_nxt = dest_r;
                  wdata_nxt = inv_val;
               end
               OP_EQ:
               begin
                  // Flags untouched, only the skip is armed
                  if (diff == 8'h00)
                  begin
                     skip_nxt = CFO_SKIP_FIRST;
                  end
               end
               OP_KICK:
               begin
                  kick_nxt = 1'b1;
                  expiry_low_nxt = 1'b1;
                  sleep_low_nxt = 1'b1;
               end
               OP_IDLE:
               begin
                  result_nxt = result_r;
               end
            endcase
         end
         PH_WRITE:
         begin
            phase_nxt = PH_DECODE;
            // Write phase stays idle for compare and kick
            if ((op_r == OP_INV) && !dest_r)
            begin
               accum_nxt = result_r;
            end
         end
      endcase
      // Preload by the host side takes the accumulator outright
      if (accum_load_i)
      begin
         accum_nxt = accum_load_data_i;
      end
      // A real expiry or sleep entry beats a kick in the same cycle
      if (watchdog_expired_i)
      begin
         expiry_low_nxt = 1'b0;
      end
      if (sleep_entry_i)
      begin
         sleep_low_nxt = 1'b0;
      end
   end

   // ***********************************************************************
   // Registers
   // ***********************************************************************
   // Clock enable low freezes everything, pulses included
   always_ff @(posedge ref_clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         phase_r <= PH_DECODE;
         op_r <= OP_IDLE;
         dest_r <= 1'b0;
         skip_r <= CFO_SKIP_NONE;
         addr_r <= '0;
         we_r <= 1'b0;
         wdata_r <= 8'h00;
         operand_r <= 8'h00;
         result_r <= 8'h00;
         accum_r <= CFO_ACCUM_RST;
         zero_r <= CFO_ZERO_FLAG_RST;
         neg_r <= CFO_NEG_FLAG_RST;
         kick_r <= 1'b0;
         expiry_low_r <= CFO_EXPIRY_LOW_RST;
         sleep_low_r <= CFO_SLEEP_LOW_RST;
      end
      else if (clk_en_i)
      begin
         phase_r <= phase_nxt;
         op_r <= op_nxt;
         dest_r <= dest_nxt;
         skip_r <= skip_nxt;
         addr_r <= addr_nxt;
         we_r <= we_nxt;
         wdata_r <= wdata_nxt;
         operand_r <= operand_nxt;
         result_r <= result_nxt;
         accum_r <= accum_nxt;
         zero_r <= zero_nxt;
         neg_r <= neg_nxt;
         kick_r <= kick_nxt;
         expiry_low_r <= expiry_low_nxt;
         sleep_low_r <= sleep_low_nxt;
      end
   end

   // ***********************************************************************
   // Outputs
   // ***********************************************************************
   assign fetch_ready_o = (phase_r == PH_DECODE);
   assign mem_addr_o = addr_r;
   assign mem_rd_o = (phase_r == PH_READ) && ((op_r == OP_ZERO) || (op_r == OP_INV) || (op_r == OP_EQ));
   assign mem_we_o = we_r;
   assign mem_wdata_o = wdata_r;
   assign accum_o = accum_r;
   assign all_clear_flag_o = zero_r;
   assign result_msb_flag_o = neg_r;
   assign watchdog_clear_o = kick_r;
   assign expiry_occurred_low_o = expiry_low_r;
   assign sleep_entered_low_o = sleep_low_r;
   assign phase_o = phase_r;
   assign skip_active_o = (skip_r != CFO_SKIP_NONE);

endmodule : cfo_core

// *** src/cfo_pkg.sv ***
// Package of encodings, phases and constants for the file-operation core
package cfo_pkg;

   // ***********************************************************************
   // Instruction encodings
   // ***********************************************************************
   localparam logic [15:0] CFO_KICK_WORD = 16'h0004;
   localparam logic [6:0] CFO_ZERO_TOP = 7'h35;    // 0110 101
   localparam logic [5:0] CFO_INV_TOP = 6'h07;     // 0001 11
   localparam logic [6:0] CFO_EQ_TOP = 7'h31;      // 0110 001
   localparam int CFO_BANK_BIT = 8;
   localparam int CFO_DEST_BIT = 9;

   // ***********************************************************************
   // Addressing constants
   // ***********************************************************************
   localparam int CFO_ADDR_W = 12;
   localparam logic [7:0] CFO_INDEX_LIMIT = 8'h5f;  // Offsets at or below use indexing
   localparam logic [7:0] CFO_ACCESS_SPLIT = 8'h60; // Lower access half ends here
   localparam logic [3:0] CFO_ACCESS_HIGH_BANK = 4'hf;
   localparam logic [3:0] CFO_ACCESS_LOW_BANK = 4'h0;

   // ***********************************************************************
   // Reset and clear values
   // ***********************************************************************
   localparam logic [7:0] CFO_ACCUM_RST = 8'h00;
   localparam logic [7:0] CFO_CLEAR_VALUE = 8'h00;
   localparam logic CFO_ZERO_FLAG_RST = 1'b0;
   localparam logic CFO_NEG_FLAG_RST = 1'b0;
   localparam logic CFO_EXPIRY_LOW_RST = 1'b1;
   localparam logic CFO_SLEEP_LOW_RST = 1'b1;

   // ***********************************************************************
   // Skip countdown codes
   // ***********************************************************************
   localparam logic [1:0] CFO_SKIP_NONE = 2'h0;
   localparam logic [1:0] CFO_SKIP_FIRST = 2'h1;
   localparam logic [1:0] CFO_SKIP_TAIL = 2'h2;

   // ***********************************************************************
   // Types
   // ***********************************************************************
   typedef enum logic [3:0]
   {
      PH_DECODE = 4'h1,
      PH_READ = 4'h2,
      PH_PROC = 4'h4,
      PH_WRITE = 4'h8
   } cfo_phase_t;

   typedef enum logic [4:0]
   {
      OP_IDLE = 5'h01,
      OP_ZERO = 5'h02,
      OP_KICK = 5'h04,
      OP_INV = 5'h08,
      OP_EQ = 5'h10
   } cfo_op_t;

endpackage : cfo_pkg

// *** bench/cfo_mem_model.sv ***
// Data memory model behind the core's memory port
`timescale 1ns/1ps

module cfo_mem_model
   import cfo_pkg::*;
(
   // Clock
   input wire logic ref_clk_i,
   // Memory port
   input wire logic [CFO_ADDR_W-1:0] mem_addr_i,
   input wire logic mem_rd_i,
   input wire logic mem_we_i,
   input wire logic [7:0] mem_wdata_i,
   output logic [7:0] mem_rdata_o
);
   logic [7:0] mem [4096];

   // Seeded contents, so the bench can predict every byte
   initial
      for (int i = 0; i < 4096; i++)
         mem[i] = i[7:0] ^ 8'ha5;

   // Outside a read the bus shows inverted data, never a stale match
   assign mem_rdata_o = mem_rd_i ? mem[mem_addr_i] : ~mem[mem_addr_i];

   // Write pulse lands on the clock edge
   always @(posedge ref_clk_i)
      if (mem_we_i)
         mem[mem_addr_i] <= mem_wdata_i;
endmodule : cfo_mem_model

// *** bench/cfo_core_properties.sv ***
// Port-level checks of the file-operation core
`timescale 1ns/1ps

module cfo_core_properties
   import cfo_pkg::*;
(
   // Clock and reset
   input wire logic ref_clk_i,
   input wire logic resetn_i,
   // Watched ports
   input wire logic clk_en_i,
   input wire logic [15:0] instr_i,
   input wire logic instr_valid_i,
   input wire logic fetch_ready_o,
   input wire logic [3:0] bank_select_reg_i,
   input wire logic ext_set_en_i,
   input wire logic [CFO_ADDR_W-1:0] index_base_i,
   input wire logic [CFO_ADDR_W-1:0] mem_addr_o,
   input wire logic mem_rd_o,
   input wire logic [7:0] mem_rdata_i,
   input wire logic mem_we_o,
   input wire logic [7:0] mem_wdata_o,
   input wire logic all_clear_flag_o,
   input wire logic result_msb_flag_o,
   input wire logic watchdog_clear_o,
   input wire logic expiry_occurred_low_o,
   input wire logic sleep_entered_low_o,
   input wire logic [3:0] phase_o
);
   logic [15:0] word_r, word_nxt;
   logic [7:0] data_r, data_nxt;

   // Word in flight and the byte it read
   always_comb
   begin
      word_nxt = (fetch_ready_o && instr_valid_i && clk_en_i) ? instr_i : word_r;
      data_nxt = (mem_rd_o && clk_en_i) ? mem_rdata_i : data_r;
   end

   always_ff @(posedge ref_clk_i or negedge resetn_i)
      if (!resetn_i)
         {word_r, data_r} <= 24'h000000;
      else
         {word_r, data_r} <= {word_nxt, data_nxt};

   default clocking cb @(posedge ref_clk_i);
   endclocking
   default disable iff (!resetn_i);

   rd_phase_a: assert property (mem_rd_o |-> phase_o == 4'h2)
      else $error("read outside read phase");
   we_phase_a: assert property (mem_we_o |-> phase_o == 4'h8 && word_r[15:9] != CFO_EQ_TOP)
      else $error("write outside write phase");
   phase_freeze_a: assert property (!clk_en_i |=> $stable(phase_o))
      else $error("phase moved while frozen");
   clear_write_a: assert property (mem_we_o && word_r[15:9] == CFO_ZERO_TOP |->
      mem_wdata_o == 8'h00 && all_clear_flag_o) else $error("clear wrote wrong");
   invert_write_a: assert property (mem_we_o && word_r[15:10] == CFO_INV_TOP |->
      word_r[9] && mem_wdata_o == ~data_r) else $error("invert wrote wrong");
   banked_addr_a: assert property (mem_rd_o && word_r[8] |->
      mem_addr_o == {bank_select_reg_i, word_r[7:0]}) else $error("banked address");
   access_addr_a: assert property (mem_rd_o && !word_r[8] && !(ext_set_en_i && word_r[7:0] <= 8'h5f) |->
      mem_addr_o == {(word_r[7:0] < 8'h60) ? 4'h0 : 4'hf, word_r[7:0]}) else $error("access address");
   indexed_addr_a: assert property (mem_rd_o && !word_r[8] && ext_set_en_i && word_r[7:0] <= 8'h5f |->
      mem_addr_o == index_base_i + {4'h0, word_r[7:0]}) else $error("indexed address");
   kick_lows_a: assert property (watchdog_clear_o |-> word_r == CFO_KICK_WORD &&
      expiry_occurred_low_o && sleep_entered_low_o) else $error("kick wrong");
   compare_flags_a: assert property (phase_o == 4'h4 && word_r[15:9] == CFO_EQ_TOP |=>
      $stable({all_clear_flag_o, result_msb_flag_o})) else $error("compare moved flags");
endmodule : cfo_core_properties

// *** bench/cfo_core_tb.sv ***
// Self-checking bench for the file-operation core
`timescale 1ns/1ps

module cfo_core_tb
   import cfo_pkg::*;
;
   logic ref_clk_i = 1'b0, resetn_i = 1'b0, clk_en_i = 1'b1, instr_valid_i = 1'b0, instr_two_word_i = 1'b0;
   logic ext_set_en_i = 1'b0, accum_load_i = 1'b0, watchdog_expired_i = 1'b0, sleep_entry_i = 1'b0;
   logic [15:0] instr_i = 16'h0000;
   logic [3:0] bank_select_reg_i = 4'h3, phase_o;
   logic [11:0] index_base_i = 12'h7c0, mem_addr_o;
   logic [7:0] accum_load_data_i = 8'h00, mem_rdata_i, mem_wdata_o, accum_o;
   logic fetch_ready_o, mem_rd_o, mem_we_o, all_clear_flag_o, result_msb_flag_o, skip_active_o;
   logic watchdog_clear_o, expiry_occurred_low_o, sleep_entered_low_o;
   logic [7:0] w_e = 8'h00, sh [4096];
   logic z_e = 1'b0, n_e = 1'b0, lo_e = 1'b1;
   logic [20:0] notes [$];
   logic [31:0] rng = 32'h0000004c;
   int error_cnt = 0, total_checks = 0, skip_left = 0;
   logic [7:0] fl [4] = '{8'h14, 8'h5f, 8'h60, 8'hc8};

   always #2 ref_clk_i = ~ref_clk_i;

   cfo_core DUT (.ref_clk_i, .resetn_i, .clk_en_i, .instr_i, .instr_valid_i, .instr_two_word_i, .fetch_ready_o,
      .bank_select_reg_i, .ext_set_en_i, .index_base_i, .mem_addr_o, .mem_rd_o, .mem_rdata_i, .mem_we_o,
      .mem_wdata_o, .accum_load_i, .accum_load_data_i, .accum_o, .all_clear_flag_o, .result_msb_flag_o,
      .watchdog_expired_i, .sleep_entry_i, .watchdog_clear_o, .expiry_occurred_low_o, .sleep_entered_low_o,
      .phase_o, .skip_active_o);
   cfo_mem_model mem_u (.ref_clk_i, .mem_addr_i(mem_addr_o), .mem_rd_i(mem_rd_o), .mem_we_i(mem_we_o),
      .mem_wdata_i(mem_wdata_o), .mem_rdata_o(mem_rdata_i));

   function automatic logic [7:0] rnd();
      rng ^= rng << 13;
      rng ^= rng >> 17;
      rng ^= rng << 5;
      return rng[7:0];
   endfunction : rnd

   // Expected data address for bank bit and offset
   function automatic logic [11:0] ea(input logic a, input logic [7:0] f);
      if (a)
         return {bank_select_reg_i, f};
      if (ext_set_en_i && f <= 8'h5f)
         return index_base_i + {4'h0, f};
      return {(f < 8'h60) ? 4'h0 : 4'hf, f};
   endfunction : ea

   task automatic check(input string what, input logic [20:0] exp, input logic [20:0] got);
      total_checks++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask : check

   task automatic final_report();
      if (error_cnt == 0 && total_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : final_report

   task automatic st();
      check("state", {8'h0, w_e, z_e, n_e, lo_e, lo_e, skip_left != 0}, {8'h0, accum_o, all_clear_flag_o,
         result_msb_flag_o, expiry_occurred_low_o, sleep_entered_low_o, skip_active_o});
   endtask : st

   // Offers one word at a falling edge, bounded wait for decode
   task automatic issue(input logic [15:0] w, input logic two);
      for (int n = 0; fetch_ready_o !== 1'b1; n++)
      begin
         if (n > 40)
         begin
            error_cnt++;
            final_report();
         end
         @(negedge ref_clk_i);
      end
      {instr_i, instr_two_word_i, instr_valid_i} = {w, two, 1'b1};
      @(negedge ref_clk_i);
      instr_valid_i = 1'b0;
   endtask : issue

   // Notes the expected effect of a word, runs it, checks the state left behind
   task automatic run(input logic [15:0] w, input logic two, input logic frz);
      logic [11:0] ad;
      logic [7:0] r;
      ad = ea(w[8], w[7:0]);
      r = ~sh[ad];
      // Skip count: 1 = next word discarded, 2 = tail of a skipped two-word instruction
      if (skip_left > 0)
         skip_left = (skip_left == 1 && two) ? 2 : 0;
      else if (w == CFO_KICK_WORD)
      begin
         notes.push_back(21'h100000);
         lo_e = 1'b1;
      end
      else if (w[15:9] == CFO_ZERO_TOP)
      begin
         notes.push_back({1'b0, ad, 8'h00});
         {sh[ad], z_e} = {8'h00, 1'b1};
      end
      else if (w[15:10] == CFO_INV_TOP)
      begin
         {z_e, n_e} = {r == 8'h00, r[7]};
         if (w[9])
         begin
            notes.push_back({1'b0, ad, r});
            sh[ad] = r;
         end
         else
            w_e = r;
      end
      else if (w[15:9] == CFO_EQ_TOP && sh[ad] == w_e)
         skip_left = 1;
      issue(w, two);
      if (frz)
      begin
         clk_en_i = 1'b0;
         repeat (3) @(negedge ref_clk_i);
         check("frozen phase", 21'h2, {17'h0, phase_o});
         clk_en_i = 1'b1;
      end
      repeat (3) @(negedge ref_clk_i);
      st();
   endtask : run

   task automatic ld(input logic [7:0] v);
      {accum_load_i, accum_load_data_i, w_e} = {1'b1, v, v};
      @(negedge ref_clk_i);
      accum_load_i = 1'b0;
   endtask : ld

   // Every write or watchdog clear consumes the oldest note
   always @(negedge ref_clk_i)
      if (mem_we_o === 1'b1 || watchdog_clear_o === 1'b1)
         check("result", (notes.size() > 0) ? notes.pop_front() : 21'h1fffff,
            watchdog_clear_o ? 21'h100000 : {1'b0, mem_addr_o, mem_wdata_o});

   // Main sequence
   initial
   begin
      logic [7:0] v, f;
      for (int i = 0; i < 4096; i++)
         sh[i] = i[7:0] ^ 8'ha5;
      repeat (4) @(negedge ref_clk_i);
      resetn_i = 1'b1;
      st();
      foreach (fl[i])
         for (int m = 0; m < 4; m++)
         begin
            ext_set_en_i = m[1];
            run({CFO_ZERO_TOP, m[0], fl[i]}, 1'b0, 1'b0);
         end
      run({CFO_INV_TOP, 2'h3, 8'h14}, 1'b0, 1'b0);
      run({CFO_INV_TOP, 2'h3, 8'h14}, 1'b0, 1'b0);
      ld(sh[ea(1'b1, 8'h42)]);
      run({CFO_EQ_TOP, 1'b1, 8'h42}, 1'b0, 1'b0);
      run({CFO_ZERO_TOP, 1'b1, 8'h43}, 1'b1, 1'b0);
      run({CFO_ZERO_TOP, 1'b1, 8'h44}, 1'b0, 1'b0);
      run({CFO_ZERO_TOP, 1'b1, 8'h45}, 1'b0, 1'b0);
      {watchdog_expired_i, sleep_entry_i, lo_e} = 3'h6;
      @(negedge ref_clk_i);
      {watchdog_expired_i, sleep_entry_i} = 2'h0;
      st();
      run(CFO_KICK_WORD, 1'b0, 1'b1);
      // Random mix; preloads force some equal compares
      for (int k = 0; k < 40; k++)
      begin
         v = rnd();
         f = rnd();
         {bank_select_reg_i, ext_set_en_i, index_base_i} = {v[3:0], v[4], v, f[3:0]};
         if (v[6:5] == 2'h2 && v[0])
            ld(sh[ea(v[7], f)]);
         case (v[6:5])
            2'h0: run({CFO_ZERO_TOP, v[7], f}, v[2], 1'b0);
            2'h1: run({CFO_INV_TOP, v[1], v[7], f}, v[2], 1'b0);
            2'h2: run({CFO_EQ_TOP, v[7], f}, v[2], 1'b0);
            default: run(CFO_KICK_WORD, v[2], 1'b0);
         endcase
      end
      repeat (8) @(negedge ref_clk_i);
      check("notes left", 21'h0, 21'(notes.size()));
      final_report();
   end
endmodule : cfo_core_tb

bind cfo_core cfo_core_properties chk (.ref_clk_i, .resetn_i, .clk_en_i, .instr_i, .instr_valid_i,
   .fetch_ready_o, .bank_select_reg_i, .ext_set_en_i, .index_base_i, .mem_addr_o, .mem_rd_o, .mem_rdata_i,
   .mem_we_o, .mem_wdata_o, .all_clear_flag_o, .result_msb_flag_o, .watchdog_clear_o, .expiry_occurred_low_o,
   .sleep_entered_low_o, .phase_o);
